/* File: hw/clock_generator_control.v */
/*
  clock generator control: main oscillator enable and start-up timing,
  main clock frequency measurement, and two pll settle timers.
  assumes slow_clock and main_clock arrive as plain levels from the analog
  macros and are sampled here on ref_clk, which must run well above both.
  control fields are plain ports driven by logic on ref_clk.
  the pll ratio itself is realised in the analog macro; this block only
  times the settle and exports the power and hold levels.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clock_generator_control_consts.vh"

//Contract
//- two plls, main oscillator, four clocks
//- reset: oscillator off, slow clock selected
//- clearing enable clears stable flag at once
//- enable rise restarts count, one step per 8
//- count zero sets stable flag, maskable irq
//- frequency count starts after next slow rise
//- sixteenth slow fall stops count, sets done
//- count equals main cycles in sixteen periods; here it spans a rise to the sixteenth fall, 15.5 periods
//- dividers accept ratios one to 255
//- zero divider holds outputs high
//- reset clears every divider field
//- output is source times mul plus one over div
//- zero multiplier powers pll down
//- change or re-enable clears lock, reloads count
//- settle counter per slow cycle, then lock
//- stable irq only when enabled
module clock_generator_control #(
  parameter OSC_W  = `OSC_COUNT_W,
  parameter FREQ_W = `FREQ_COUNT_W,
  parameter DIV_W  = `PLL_DIV_W,
  parameter MUL_W  = `PLL_MUL_W,
  parameter CNT_W  = `PLL_CNT_W
) (
  input  wire              ref_clk,              // block clock, 10 MHz
  input  wire              rst,                  // synchronous, active high
  input  wire              slow_clock,           // permanent slow clock pin
  input  wire              main_clock,           // main oscillator output pin
  input  wire              main_osc_enable,      // oscillator enable field
  input  wire              osc_external_input,   // bypass field
  input  wire [OSC_W-1:0]  osc_startup_count,    // start-up count field
  input  wire [DIV_W-1:0]  pll_a_div,            // pll a divider field
  input  wire [MUL_W-1:0]  pll_a_scale_factor,   // pll a multiplier field
  input  wire [CNT_W-1:0]  pll_a_settle_count,   // pll a settle count field
  input  wire [DIV_W-1:0]  pll_b_div,            // pll b divider field
  input  wire [MUL_W-1:0]  pll_b_scale_factor,   // pll b multiplier field
  input  wire [CNT_W-1:0]  pll_b_settle_count,   // pll b settle count field
  input  wire [`MASK_W-1:0] interrupt_mask,      // interrupt mask bits
  output wire              osc_power_on,         // analog oscillator enable
  output wire              osc_bypass_out,       // analog bypass select
  output wire              main_clock_selected,  // 0: slow clock is source
  output reg               main_osc_stable,      // stable flag
  output reg               freq_measure_done,    // measurement done flag
  output reg  [FREQ_W-1:0] main_freq_count,      // measured main cycles
  output wire              pll_a_enable,         // pll a powered
  output wire              pll_a_hold_high,      // pll a output held at 1
  output wire              pll_a_settled,        // pll a lock flag
  output wire              pll_b_enable,         // pll b powered
  output wire              pll_b_hold_high,      // pll b output held at 1
  output wire              pll_b_settled,        // pll b lock flag
  output wire              irq                   // level interrupt request
);

  // measurement state machine, one-hot; a stray code falls back to idle
  // through the default branch, so a flipped bit costs one measurement
  // at worst and never a stuck counter
  localparam [2:0] M_IDLE = 3'b001;  // waiting for stable
  localparam [2:0] M_ARM  = 3'b010;  // waiting for next slow rise
  localparam [2:0] M_RUN  = 3'b100;  // counting main cycles

  // synchronised pins, their edges and the timer state
  wire                      slow_sync;     // synchronised slow clock
  wire                      main_sync;     // synchronised main clock
  reg                       slow_d_ff;     // previous slow level
  reg                       main_d_ff;     // previous main level
  wire                      slow_rise;     // slow rising edge pulse
  wire                      slow_fall;     // slow falling edge pulse
  wire                      main_rise;     // main rising edge pulse
  reg                       en_d_ff;       // previous enable level
  reg [`OSC_PRESCALE_W-1:0] pre_ff;        // divide-by-8 prescaler
  reg [OSC_W-1:0]           osc_cnt_ff;    // start-up counter
  reg                       osc_run_ff;    // start-up count active
  reg [2:0]                 m_state_ff;    // measurement state
  reg [2:0]                 nxt_m_state;   // next measurement state
  reg [`MEASURE_PERIODS_W-1:0] fall_cnt_ff; // slow falls counted
  reg                       meas_done_ff;  // one measure per stable period
  wire                      irq_osc;       // stable flag, masked
  wire                      irq_lka;       // pll a lock, masked
  wire                      irq_lkb;       // pll b lock, masked
  wire                      irq_done;      // measurement done, masked

  // slow and main are foreign to ref_clk: two stages before any use.
  // the stages add about two ref_clk cycles to every edge; both pins
  // pay the same delay, so measured intervals are not skewed by it
  sync_2ff u_slow_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (slow_clock),
    .sync_out (slow_sync)
  );

  // main clock pin; expected low while the oscillator is off
  sync_2ff u_main_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (main_clock),
    .sync_out (main_sync)
  );

  // edge detection on synchronised levels only; the previous-level
  // registers reset low, so a slow level already high at release reads
  // as one rise, which at most shortens the first timer step
  always @(posedge ref_clk) begin
    if (rst) begin
      slow_d_ff <= 1'b0;
      main_d_ff <= 1'b0;
    end else begin
      slow_d_ff <= slow_sync;
      main_d_ff <= main_sync;
    end
  end

  // one-cycle pulses, each seen by exactly one ref_clk edge
  assign slow_rise = slow_sync & ~slow_d_ff;
  assign slow_fall = ~slow_sync & slow_d_ff;
  assign main_rise = main_sync & ~main_d_ff;

  // oscillator drive follows the enable; bypass is software's business.
  // nothing here stops bypass and enable being high together, which is a
  // misuse the caller must avoid
  assign osc_power_on        = main_osc_enable;
  assign osc_bypass_out      = osc_external_input;
  // slow clock is always the source; the selection is tied to zero
  assign main_clock_selected = 1'b0;

  // start-up timer: restart on enable rise, one step per 8 slow periods.
  // the prescaler restarts with every load so the first step is a full
  // eight periods; a count of n sets the flag on rise 8n+1, so even a
  // zero count waits for one slow edge.
  // holding enable high is no restart: only the rise reloads
  always @(posedge ref_clk) begin
    if (rst) begin
      // oscillator off, nothing counting, flag low
      en_d_ff         <= 1'b0;
      pre_ff          <= {`OSC_PRESCALE_W{1'b0}};
      osc_cnt_ff      <= `RST_OSC_COUNT;
      osc_run_ff      <= 1'b0;
      main_osc_stable <= 1'b0;
    end else begin
      en_d_ff <= main_osc_enable;
      if (!main_osc_enable) begin
        // disabled: flag drops in the same cycle
        main_osc_stable <= 1'b0;
        osc_run_ff      <= 1'b0;
      end else if (!en_d_ff) begin
        // fresh enable: load the start-up value
        main_osc_stable <= 1'b0;
        osc_cnt_ff      <= osc_startup_count;
        pre_ff          <= {`OSC_PRESCALE_W{1'b0}};
        osc_run_ff      <= 1'b1;
      end else if (osc_run_ff && slow_rise) begin
        // prescaler wraps by itself after eight rises
        pre_ff <= pre_ff + 1'b1;
        if (osc_cnt_ff == {OSC_W{1'b0}}) begin
          main_osc_stable <= 1'b1;
          osc_run_ff      <= 1'b0;
        end else if (pre_ff == `OSC_PRESCALE - 1) begin
          osc_cnt_ff <= osc_cnt_ff - 1'b1;
        end
      end
    end
  end

  // measurement next state: arm once per stable period, open the window
  // on the next synchronised slow rise, close it on the sixteenth fall
  always @* begin
    nxt_m_state = m_state_ff;
    case (m_state_ff)
      M_IDLE: begin
        // one measurement per stable period
        if (main_osc_stable && !meas_done_ff) begin
          nxt_m_state = M_ARM;
        end
      end
      M_ARM: begin
        if (!main_osc_stable) begin
          nxt_m_state = M_IDLE;
        end else if (slow_rise) begin
          nxt_m_state = M_RUN;
        end
      end
      M_RUN: begin
        if (!main_osc_stable) begin
          nxt_m_state = M_IDLE;
        end else if (slow_fall &&
                     fall_cnt_ff == `MEASURE_PERIODS - 1) begin
          nxt_m_state = M_IDLE;
        end
      end
      default: begin
        // illegal code: back to idle
        nxt_m_state = M_IDLE;
      end
    endcase
  end

  // measurement counters and flags; count and done stand until the
  // oscillator is disabled, so software may read them at leisure.
  // a main clock above half of ref_clk aliases and reads low here
  always @(posedge ref_clk) begin
    if (rst) begin
      m_state_ff        <= M_IDLE;
      fall_cnt_ff       <= {`MEASURE_PERIODS_W{1'b0}};
      main_freq_count   <= {FREQ_W{1'b0}};
      freq_measure_done <= 1'b0;
      meas_done_ff      <= 1'b0;
    end else begin
      m_state_ff <= nxt_m_state;
      if (!main_osc_stable) begin
        // oscillator lost: result no longer valid
        freq_measure_done <= 1'b0;
        meas_done_ff      <= 1'b0;
      end
      case (m_state_ff)
        M_ARM: begin
          // window not open yet: both counts start from zero
          fall_cnt_ff     <= {`MEASURE_PERIODS_W{1'b0}};
          main_freq_count <= {FREQ_W{1'b0}};
        end
        M_RUN: begin
          if (main_rise) begin
            // saturation would hide nothing at these widths
            main_freq_count <= main_freq_count + 1'b1;
          end
          if (slow_fall) begin
            // sixteenth fall closes the window and raises done
            fall_cnt_ff <= fall_cnt_ff + 1'b1;
            if (fall_cnt_ff == `MEASURE_PERIODS - 1 && main_osc_stable) begin
              freq_measure_done <= 1'b1;
              meas_done_ff      <= 1'b1;
            end
          end
        end
        default: begin
          fall_cnt_ff <= fall_cnt_ff;
        end
      endcase
    end
  end

  // two identical pll paths; ratio (mul+1)/div is realised in the macro.
  // both share the synchronised slow rise as their tick, so the settle
  // counts of the two plls run on one time base
  pll_settle #(
    .DIV_W (DIV_W),
    .MUL_W (MUL_W),
    .CNT_W (CNT_W)
  ) u_pll_a (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .slow_tick    (slow_rise),
    .div          (pll_a_div),
    .mul          (pll_a_scale_factor),
    .settle_count (pll_a_settle_count),
    .pll_enable   (pll_a_enable),
    .hold_high    (pll_a_hold_high),
    .settled      (pll_a_settled)
  );

  pll_settle #(
    .DIV_W (DIV_W),
    .MUL_W (MUL_W),
    .CNT_W (CNT_W)
  ) u_pll_b (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .slow_tick    (slow_rise),
    .div          (pll_b_div),
    .mul          (pll_b_scale_factor),
    .settle_count (pll_b_settle_count),
    .pll_enable   (pll_b_enable),
    .hold_high    (pll_b_hold_high),
    .settled      (pll_b_settled)
  );

  // each flag gated by its own mask bit; the request is a level, so it
  // drops as soon as the flag clears or software masks it again
  assign irq_osc  = main_osc_stable & interrupt_mask[`MASK_STABLE_BIT];
  assign irq_lka  = pll_a_settled & interrupt_mask[`MASK_LOCK_A_BIT];
  assign irq_lkb  = pll_b_settled & interrupt_mask[`MASK_LOCK_B_BIT];
  assign irq_done = freq_measure_done & interrupt_mask[`MASK_DONE_BIT];
  // polled software sees the same flags whether or not they are masked
  assign irq      = irq_osc | irq_lka | irq_lkb | irq_done;

endmodule // clock_generator_control

`default_nettype wire

/* File: common/clock_generator_control_consts.vh */
/*
  constants for the clock generator control block: field widths, reset
  values and timing counts. assumes inclusion by bare name.
*/
`ifndef CLOCK_GENERATOR_CONTROL_CONSTS_VH
`define CLOCK_GENERATOR_CONTROL_CONSTS_VH

// slow clock prescale for the oscillator start-up count
`define OSC_PRESCALE          8
`define OSC_PRESCALE_W        3
// start-up count width
`define OSC_COUNT_W           8
// measurement length in slow clock falls after the opening rise
`define MEASURE_PERIODS       16
`define MEASURE_PERIODS_W     5
// main frequency count width
`define FREQ_COUNT_W          16
// pll divider, multiplier and settle count widths
`define PLL_DIV_W             8
`define PLL_MUL_W             11
`define PLL_CNT_W             6
// reset values
`define RST_DIV               8'h00
`define RST_MUL               11'h000
`define RST_CNT               6'h00
`define RST_OSC_COUNT         8'h00
// interrupt mask bit positions
`define MASK_STABLE_BIT       0
`define MASK_LOCK_A_BIT       1
`define MASK_LOCK_B_BIT       2
`define MASK_DONE_BIT         3
`define MASK_W                4

`endif

/* File: hw/sync_2ff.v */
/*
  two flip-flop level synchroniser into the ref_clk domain.
  assumes the input is a level from an unrelated clock or pin.
*/
`timescale 1ns/1ns
`default_nettype none

module sync_2ff (
  input  wire ref_clk,   // destination clock
  input  wire rst,       // synchronous, active high
  input  wire async_in,  // level from another domain
  output wire sync_out   // synchronised level
);

  reg stage1_ff;  // first stage, read only by stage2
  reg stage2_ff;  // second stage, safe to use

  // two stages; reset clears both
  always @(posedge ref_clk) begin
    if (rst) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule // sync_2ff

`default_nettype wire

/* File: hw/pll_settle.v */
/*
  one pll path: parameter change detection, settle counter, settled flag,
  power-down and divider-zero hold. assumes slow_tick is a one-cycle pulse
  per rising slow clock edge in the ref_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clock_generator_control_consts.vh"

module pll_settle #(
  parameter DIV_W = `PLL_DIV_W,
  parameter MUL_W = `PLL_MUL_W,
  parameter CNT_W = `PLL_CNT_W
) (
  input  wire             ref_clk,       // block clock
  input  wire             rst,           // synchronous, active high
  input  wire             slow_tick,     // one pulse per slow clock period
  input  wire [DIV_W-1:0] div,           // input divider field
  input  wire [MUL_W-1:0] mul,           // pll_scale_factor field
  input  wire [CNT_W-1:0] settle_count,  // pll_settle_count field
  output wire             pll_enable,    // analog pll powered
  output wire             hold_high,     // divider and pll output held at 1
  output reg              settled        // lock flag
);

  reg [DIV_W-1:0] div_ff;   // last seen divider
  reg [MUL_W-1:0] mul_ff;   // last seen multiplier
  reg [CNT_W-1:0] cnt_ff;   // settle counter
  reg             run_ff;   // counting in progress
  wire            changed;  // divider or multiplier moved

  assign changed    = (div != div_ff) || (mul != mul_ff);
  assign pll_enable = (mul != {MUL_W{1'b0}});
  assign hold_high  = (div == {DIV_W{1'b0}});

  // restart on change, count down per slow period, then settle
  always @(posedge ref_clk) begin
    if (rst) begin
      div_ff  <= `RST_DIV;
      mul_ff  <= `RST_MUL;
      cnt_ff  <= `RST_CNT;
      run_ff  <= 1'b0;
      settled <= 1'b0;
    end else begin
      div_ff <= div;
      mul_ff <= mul;
      if (changed && pll_enable) begin
        // reload and drop the flag
        settled <= 1'b0;
        cnt_ff  <= settle_count;
        run_ff  <= 1'b1;
      end else if (!pll_enable) begin
        // powered down pll never locks
        settled <= 1'b0;
        run_ff  <= 1'b0;
      end else if (run_ff && slow_tick) begin
        if (cnt_ff == {CNT_W{1'b0}}) begin
          settled <= 1'b1;
          run_ff  <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end

endmodule // pll_settle

`default_nettype wire

/* File: verification/clock_generator_control_chk.sv */
/*
  port checker for clock_generator_control, bound to the top module.
  assumes ref_clk is the only clock and rst is synchronous active high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clock_generator_control_consts.vh"
module clock_generator_chk #(
  parameter DIV_W = `PLL_DIV_W,
  parameter MUL_W = `PLL_MUL_W
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               main_osc_enable,
  input wire logic               osc_external_input,
  input wire logic [DIV_W-1:0]   pll_a_div,
  input wire logic [MUL_W-1:0]   pll_a_scale_factor,
  input wire logic [DIV_W-1:0]   pll_b_div,
  input wire logic [MUL_W-1:0]   pll_b_scale_factor,
  input wire logic [`MASK_W-1:0] interrupt_mask,
  input wire logic               osc_power_on,
  input wire logic               osc_bypass_out,
  input wire logic               main_clock_selected,
  input wire logic               main_osc_stable,
  input wire logic               freq_measure_done,
  input wire logic               pll_a_enable,
  input wire logic               pll_a_hold_high,
  input wire logic               pll_a_settled,
  input wire logic               pll_b_enable,
  input wire logic               pll_b_hold_high,
  input wire logic               pll_b_settled,
  input wire logic               irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a parameter change on a powered pll
  sequence pll_a_touch;
    ($changed(pll_a_div) || $changed(pll_a_scale_factor))
      && (pll_a_scale_factor != 0);
  endsequence
  // enable high at the edge that set the flag and at the one before
  sequence osc_held;
    $past(main_osc_enable, 2) && $past(main_osc_enable);
  endsequence
  osc_power_a: assert property (osc_power_on == main_osc_enable)
    else $error("oscillator power does not follow enable");
  bypass_path_a: assert property (osc_bypass_out == osc_external_input)
    else $error("bypass select does not follow field");
  slow_source_a: assert property (main_clock_selected == 1'b0)
    else $error("main clock selected as source");
  stable_clear_a: assert property (!main_osc_enable |=> !main_osc_stable)
    else $error("stable flag kept after disable");
  stable_cause_a: assert property ($rose(main_osc_stable)
    |-> osc_held)
    else $error("stable flag rose without enable");
  pll_hold_a: assert property ((pll_a_hold_high == (pll_a_div == 0))
    && (pll_b_hold_high == (pll_b_div == 0)))
    else $error("hold high does not match divider zero");
  pll_power_a: assert property (
    (pll_a_enable == (pll_a_scale_factor != 0))
    && (pll_b_enable == (pll_b_scale_factor != 0)))
    else $error("pll power does not match multiplier");
  lock_clear_a: assert property (pll_a_touch |=> !pll_a_settled)
    else $error("lock flag kept after change");
  lock_cause_a: assert property ($rose(pll_a_settled)
    |-> $past(pll_a_enable))
    else $error("lock flag rose on powered down pll");
  done_cause_a: assert property ($rose(freq_measure_done)
    |-> $past(main_osc_stable))
    else $error("measurement done without stable oscillator");
  irq_level_a: assert property (irq == |({freq_measure_done,
    pll_b_settled, pll_a_settled, main_osc_stable} & interrupt_mask))
    else $error("irq differs from masked flags");
endmodule // clock_generator_chk
bind clock_generator_control clock_generator_chk #(
  .DIV_W(DIV_W), .MUL_W(MUL_W)) clock_generator_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .main_osc_enable(main_osc_enable),
  .osc_external_input(osc_external_input), .pll_a_div(pll_a_div),
  .pll_a_scale_factor(pll_a_scale_factor), .pll_b_div(pll_b_div),
  .pll_b_scale_factor(pll_b_scale_factor), .interrupt_mask(interrupt_mask),
  .osc_power_on(osc_power_on), .osc_bypass_out(osc_bypass_out),
  .main_clock_selected(main_clock_selected),
  .main_osc_stable(main_osc_stable), .freq_measure_done(freq_measure_done),
  .pll_a_enable(pll_a_enable), .pll_a_hold_high(pll_a_hold_high),
  .pll_a_settled(pll_a_settled), .pll_b_enable(pll_b_enable),
  .pll_b_hold_high(pll_b_hold_high), .pll_b_settled(pll_b_settled),
  .irq(irq));
`default_nettype wire

/* File: verification/clock_macro_model.sv */
/*
  behavioural analog side: slow clock and main oscillator pins.
  assumes the bench runs ref_clk at 10 MHz; both pins are unrelated to it.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_macro_model (
  input  wire logic osc_power_on,    // oscillator powered
  input  wire logic osc_bypass_out,  // external clock on the input pin
  output var  logic slow_clock,      // permanent slow clock
  output var  logic main_clock       // main clock, stops when off
);
  // slow clock runs free, 1600 ns period, offset from ref_clk edges
  initial begin
    slow_clock = 1'b0;
    #10;
    forever #800 slow_clock = ~slow_clock;
  end
  // main clock 400 ns period; slow enough for 10 MHz edge sampling
  initial begin
    main_clock = 1'b0;
    #30;
    forever begin
      #200;
      if (osc_power_on || osc_bypass_out) main_clock = ~main_clock;
      else main_clock = 1'b0;
    end
  end
endmodule // clock_macro_model
`default_nettype wire

/* File: verification/clock_generator_control_tb_top.sv */
/*
  self-checking bench for clock_generator_control with the analog model.
  assumes the bound checker and clock_macro_model are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_generator_control_tb_top;
  logic        ref_clk = 1'b0;    // 10 MHz block clock
  logic        rst     = 1'b1;    // held for two cycles
  logic        en      = 1'b0;    // oscillator enable field
  logic        byp     = 1'b0;    // bypass field
  logic [7:0]  cnt     = 8'h00;   // start-up count
  logic [7:0]  div_a   = 8'h00;
  logic [7:0]  div_b   = 8'h00;
  logic [10:0] mul_a   = 11'h000;
  logic [10:0] mul_b   = 11'h000;
  logic [5:0]  sc_a    = 6'h00;
  logic [5:0]  sc_b    = 6'h00;
  logic [3:0]  mask    = 4'h0;
  wire slow_clock, main_clock, pwr, byp_o, sel, stb, done, irq;
  wire ena_a, hold_a, lk_a, ena_b, hold_b, lk_b;
  wire [15:0] freq;
  wire [3:0]  flags = {done, lk_b, lk_a, stb};  // mask bit order
  integer err_total = 0;
  integer checked   = 0;
  integer rises     = 0;  // slow clock rises seen on the pin
  integer t0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge slow_clock) rises = rises + 1;
  clock_macro_model clock_macro_model_inst (.osc_power_on(pwr),
    .osc_bypass_out(byp_o), .slow_clock(slow_clock), .main_clock(main_clock));
  clock_generator_control clock_generator_control_inst (.ref_clk(ref_clk),
    .rst(rst), .slow_clock(slow_clock), .main_clock(main_clock),
    .main_osc_enable(en), .osc_external_input(byp),
    .osc_startup_count(cnt), .pll_a_div(div_a), .pll_a_scale_factor(mul_a),
    .pll_a_settle_count(sc_a), .pll_b_div(div_b), .pll_b_scale_factor(mul_b),
    .pll_b_settle_count(sc_b), .interrupt_mask(mask), .osc_power_on(pwr),
    .osc_bypass_out(byp_o), .main_clock_selected(sel),
    .main_osc_stable(stb), .freq_measure_done(done), .main_freq_count(freq),
    .pll_a_enable(ena_a), .pll_a_hold_high(hold_a), .pll_a_settled(lk_a),
    .pll_b_enable(ena_b), .pll_b_hold_high(hold_b), .pll_b_settled(lk_b),
    .irq(irq));
  // one comparison, x never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic idle(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  // bounded wait for one flag; running out ends the run
  task automatic wait_bit(input integer idx);
    integer n;
    n = 0;
    while (flags[idx] !== 1'b1 && n < 700) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    if (n >= 700) begin
      err_total = err_total + 1;
      complete_run;
    end
  endtask
  // fields of one pll, changed after a falling edge; the reserved pll a
  // bit that software must set has no port here, nothing to drive
  task automatic set_pll(input integer p, input logic [7:0] d,
                         input logic [10:0] m, input logic [5:0] s);
    @(negedge ref_clk);
    if (p == 1) begin
      div_a = d;
      mul_a = m;
      sc_a  = s;
    end else begin
      div_b = d;
      mul_b = m;
      sc_b  = s;
    end
  endtask
  // lock timing, relock on change, power down, zero divider
  task automatic pll_try(input integer p);
    set_pll(p, 8'h01, 11'h005, 6'h03);
    t0 = rises;
    idle(2);
    check(flags[p], 1'b0);
    wait_bit(p);
    check((rises - t0) >= 3 && (rises - t0) <= 6, 1'b1);
    check(p == 1 ? {ena_a, hold_a} : {ena_b, hold_b}, 2'b10);
    mask = 4'h1 << p;
    idle(1);
    check(irq, 1'b1);
    set_pll(p, 8'hff, 11'h005, 6'h03);
    idle(2);
    check({flags[p], irq}, 2'b00);
    wait_bit(p);
    set_pll(p, 8'hff, 11'h000, 6'h03);
    idle(2);
    check(p == 1 ? {ena_a, lk_a} : {ena_b, lk_b}, 2'b00);
    set_pll(p, 8'h00, 11'h005, 6'h03);
    idle(2);
    check(p == 1 ? {ena_a, hold_a} : {ena_b, hold_b}, 2'b11);
    check(p == 1 ? lk_a : lk_b, 1'b0);
    mask = 4'h0;
  endtask
  // main sequence
  initial begin
    idle(2);
    rst = 1'b0;
    idle(1);
    check({sel, stb, done, freq, irq, pwr}, 21'h0);
    check({ena_a, hold_a, lk_a, ena_b, hold_b, lk_b}, 6'b010010);
    byp = 1'b1;
    idle(1);
    check({byp_o, pwr}, 2'b10);
    byp = 1'b0;
    cnt = 8'h02;
    en  = 1'b1;
    t0  = rises;
    wait_bit(0);
    check((rises - t0) >= 15 && (rises - t0) <= 19, 1'b1);
    check(irq, 1'b0);
    mask = 4'h1;
    idle(1);
    check(irq, 1'b1);
    mask = 4'h8;
    t0   = rises;
    wait_bit(3);
    check((rises - t0) >= 15 && (rises - t0) <= 18, 1'b1);
    check(freq >= 16'h003c && freq <= 16'h0042, 1'b1);
    check(irq, 1'b1);
    mask = 4'h0;
    en   = 1'b0;
    idle(3);
    check({stb, done, pwr}, 3'b000);
    pll_try(1);
    pll_try(2);
    complete_run;
  end
endmodule // clock_generator_control_tb_top
`default_nettype wire
